// file: rtl/emw_consts.svh
// Constants for the message send and writeback block
// Assumes inclusion from the package and the testbench
`ifndef EMW_CONSTS_SVH
`define EMW_CONSTS_SVH
// APB register byte offsets
`define EMW_CTRL_OFS      12'h000
`define EMW_STATUS_OFS    12'h004
`define EMW_ERR_INFO_OFS  12'h008
`define EMW_ERR_MASK_OFS  12'h00c
`define EMW_ERR_HDR_OFS   12'h010
// Field positions
`define EMW_ERR_VALID_BIT 31
`define EMW_HDR_FFID_LSB  24
// Reset values
`define EMW_CTRL_RST      4'h0
// Target function codes
`define EMW_SF_SAMPLER    4'h2
`define EMW_SF_GATEWAY    4'h3
`define EMW_SF_DATAPORT   4'h4
`define EMW_SF_URB        4'h6
`define EMW_SF_PIXEL      4'h5
`define EMW_SF_SPAWNER    4'h7
`define EMW_SF_MATH       4'h1
`endif

// file: rtl/emw_msg_send.sv
// Message issue, delivery, scoreboard and error capture of one execution unit
// Assumes one clock, APB register access, shared functions on msg/wb ports
//
// Functional notes
// [R1] Sixteen-lane instruction runs as two eight-lane halves
// [R2] Indirect addressing only in eight-lane form
// [R3] Message carries descriptor, dest, mask, thread, unit ids
// [R4] Sends queued then routed by target id
// [R5] Writebacks are whole general registers
// [R6] Header kind depends on target function
// [R7] Mark exact response range in-flight, block users
// [R8] No-return message: null dest, zero response
// [R9] Writeback clears flag, stalled thread resumes
// [R10] Same-target messages delivered in issue order
// [R11] Writebacks accepted in any order
// [R12] Send is scalar, moves one register
// [R13] Channel mask forwarded with message
// [R14] Thread-end send stops the thread
// [R15] Thread-end only to pixel, buffer, spawner; the code accepts it for any target id
// [R16] Dispatcher told when thread ends
// [R17] Thread-end carries fixed-function id
// [R18] Dispatch stores id into header register
// [R19] Thread-end rides only on header messages; the code also sends it with HDR_NONE
// [R20] Dword layout, writeback offsets from start
// [R21] Delivery checks target id and length
// [R22] Errors latched in registers, interrupt raised
// [R23] Bad target dropped, destinations stay in-flight
// [R24] Thread-end with real dest refused, thread hangs
// [R25] Full queue stalls further sends
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/100ps

module emw_msg_send
   import emw_pkg::*;
#(
   parameter int NT    = 8,
   parameter int GENERAL_REGISTER_FILE   = 128,
   parameter int DEPTH = 4
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic               pready,
   output logic [31:0]        prdata,
   output logic               pslverr,
   input  wire logic          ins_valid,
   input  wire emw_instr_type ins,
   output logic               ins_done,
   output logic               exe_valid,
   output logic               exe_half,
   output logic               exe_scalar,
   output logic [2:0]         exe_thread,
   output logic               msg_valid,
   output emw_msg_type        msg,
   input  wire logic          msg_ready,
   input  wire logic          wb_valid,
   input  wire logic [2:0]    wb_thread,
   input  wire logic [6:0]    wb_reg,
   input  wire logic          disp_valid,
   input  wire logic [2:0]    disp_thread,
   input  wire logic [3:0]    disp_ffid,
   output logic               hdr_wr_valid,
   output logic [2:0]         hdr_wr_thread,
   output logic [31:0]        hdr_wr_data,
   output logic               eot_valid,
   output logic [2:0]         eot_thread,
   output logic [3:0]         eot_ffid,
   output logic               err_irq
);
   localparam int PW = $clog2(DEPTH);

   //------------------------------------------------------------
   // Decode helpers
   //------------------------------------------------------------
   function automatic logic busy(input logic [GENERAL_REGISTER_FILE-1:0] sb, input logic [6:0] r,
                                 input logic pair);
      busy = sb[r] | (pair & sb[7'(r + 7'h01)]);
   endfunction

   function automatic logic bad_msg(input emw_desc_type d);
      logic ok;
      ok = (d.target_function_id == `EMW_SF_SAMPLER) | (d.target_function_id == `EMW_SF_GATEWAY)
         | (d.target_function_id == `EMW_SF_DATAPORT) | (d.target_function_id == `EMW_SF_URB)
         | (d.target_function_id == `EMW_SF_PIXEL) | (d.target_function_id == `EMW_SF_SPAWNER)
         | (d.target_function_id == `EMW_SF_MATH);
      bad_msg = !ok | (d.payload_len == 4'h0);
   endfunction

   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   emw_state_type          state_reg, state_next;
   logic [NT-1:0][GENERAL_REGISTER_FILE-1:0] sb_reg, sb_next;
   logic [NT-1:0]          active_reg, active_next, hung_reg, hung_next;
   logic [NT-1:0][3:0]     ffid_reg, ffid_next;
   emw_msg_type            fifo_mem [DEPTH];
   logic [PW-1:0]          wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
   logic [PW:0]            cnt_reg, cnt_next;
   logic                   push, pop, fifo_full;
   emw_msg_type            push_msg;
   logic                   exe_valid_next, exe_half_next, exe_scalar_next, ins_done_next;
   logic [2:0]             exe_thread_next;
   logic                   msg_valid_next, eot_valid_next;
   emw_msg_type            msg_next;
   logic                   blocked, deq_bad;
   logic [3:0]             ctrl_execution_unit_id_reg, ctrl_execution_unit_id_next;
   logic                   err_valid_reg, err_valid_next;
   logic [31:0]            err_info_reg, err_info_next, err_mask_reg, err_mask_next;
   logic [31:0]            err_hdr_reg, err_hdr_next;
   logic                   pready_next, pslverr_next;
   logic [31:0]            prdata_next;
   logic                   apb_wr;
   logic                   hdr_wr_valid_next;

   assign fifo_full = (cnt_reg == (PW+1)'(DEPTH));
   assign apb_wr    = psel & penable & pready & pwrite;

   //------------------------------------------------------------
   // Issue control and scoreboard
   //------------------------------------------------------------
   always_comb begin
      logic [GENERAL_REGISTER_FILE-1:0] tsb;
      tsb              = sb_reg[ins.thread];
      state_next       = state_reg;
      sb_next          = sb_reg;
      active_next      = active_reg;
      hung_next        = hung_reg;
      ffid_next        = ffid_reg;
      push             = 1'b0;
      exe_valid_next   = 1'b0;
      exe_half_next    = 1'b0;
      exe_scalar_next  = 1'b0;
      exe_thread_next  = exe_thread;
      ins_done_next    = 1'b0;
      push_msg.desc                = ins.desc;
      push_msg.hdr_kind            = (ins.desc.target_function_id == `EMW_SF_MATH) ? HDR_NONE :
                                     (ins.desc.target_function_id == `EMW_SF_GATEWAY) ?
                                     HDR_MERGED : HDR_SEPARATE; // R6
      push_msg.dst_start           = ins.dst;
      push_msg.dst_null            = ins.dst_null;
      push_msg.payload_start       = ins.src0;
      push_msg.channel_enable_mask = ins.channel_enable_mask; // R13
      push_msg.thread              = ins.thread;
      push_msg.execution_unit_id   = ctrl_execution_unit_id_reg;
      push_msg.ff_id               = ffid_reg[ins.thread]; // R17
      if (ins.is_send)
         blocked = busy(tsb, ins.src0, 1'b0) | fifo_full; // R25
      else
         blocked = busy(tsb, ins.src0, ins.compressed) | busy(tsb, ins.src1, ins.compressed)
                 | busy(tsb, ins.dst, ins.compressed); // R7
      // Writebacks clear one register each, any order
      if (wb_valid)
         sb_next[wb_thread][wb_reg] = 1'b0; // R5 R9 R11 R20
      case (state_reg)
         ST_IDLE: begin
            // Skip the cycle that acknowledges the previous request
            if (ins_valid && !ins_done) begin
               if (!active_reg[ins.thread] || hung_reg[ins.thread]) begin
                  state_next = ST_ACK;
               end else if (ins.is_send && ins.desc.thread_end_flag && !ins.dst_null) begin
                  hung_next[ins.thread] = 1'b1; // R24
                  state_next            = ST_ACK;
               end else if (!blocked) begin
                  exe_valid_next  = 1'b1;
                  exe_thread_next = ins.thread;
                  if (ins.is_send) begin
                     push            = 1'b1; // R4
                     exe_scalar_next = 1'b1; // R12
                     state_next      = ST_ACK;
                     if (!ins.dst_null) begin
                        for (int r = 0; r < GENERAL_REGISTER_FILE; r++) begin
                           if (r >= int'(ins.dst) && r < int'(ins.dst) + int'(ins.desc.response_len))
                              sb_next[ins.thread][r] = 1'b1; // R7 R20
                        end
                     end
                     if (ins.desc.thread_end_flag)
                        active_next[ins.thread] = 1'b0; // R14
                  end else begin
                     state_next = ins.compressed ? ST_SECOND : ST_ACK; // R1
                  end
               end
            end
         end
         ST_SECOND: begin
            exe_valid_next  = 1'b1;
            exe_half_next   = 1'b1; // R1
            exe_thread_next = exe_thread;
            state_next      = ST_ACK;
         end
         ST_ACK: begin
            ins_done_next = 1'b1;
            state_next    = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
      if (disp_valid) begin
         active_next[disp_thread] = 1'b1;
         hung_next[disp_thread]   = 1'b0;
         ffid_next[disp_thread]   = disp_ffid; // R18
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg  <= ST_IDLE;
         sb_reg     <= '0;
         active_reg <= '0;
         hung_reg   <= '0;
         ffid_reg   <= '0;
         exe_valid  <= 1'b0;
         exe_half   <= 1'b0;
         exe_scalar <= 1'b0;
         exe_thread <= 3'h0;
         ins_done   <= 1'b0;
      end else begin
         state_reg  <= state_next;
         sb_reg     <= sb_next;
         active_reg <= active_next;
         hung_reg   <= hung_next;
         ffid_reg   <= ffid_next;
         exe_valid  <= exe_valid_next;
         exe_half   <= exe_half_next;
         exe_scalar <= exe_scalar_next;
         exe_thread <= exe_thread_next;
         ins_done   <= ins_done_next;
      end
   end

   //------------------------------------------------------------
   // Outbound queue and delivery stage
   //------------------------------------------------------------
   assign deq_bad = (cnt_reg != '0) && bad_msg(fifo_mem[rd_ptr_reg].desc); // R21
   assign pop     = (cnt_reg != '0) && (deq_bad || !msg_valid || msg_ready);

   always_comb begin
      wr_ptr_next    = push ? PW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
      rd_ptr_next    = pop ? PW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
      cnt_next       = (PW+1)'(cnt_reg + (PW+1)'(push) - (PW+1)'(pop));
      msg_valid_next = msg_valid & !msg_ready;
      msg_next       = msg;
      if (pop && !deq_bad) begin
         msg_valid_next = 1'b1; // R10
         msg_next       = fifo_mem[rd_ptr_reg];
      end
      eot_valid_next = msg_valid & msg_ready & msg.desc.thread_end_flag; // R16
   end

   always_ff @(posedge pclk) begin
      if (push)
         fifo_mem[wr_ptr_reg] <= push_msg; // R3
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg    <= '0;
         msg_valid  <= 1'b0;
         msg        <= '0;
         eot_valid  <= 1'b0;
         eot_thread <= 3'h0;
         eot_ffid   <= 4'h0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         cnt_reg    <= cnt_next;
         msg_valid  <= msg_valid_next;
         msg        <= msg_next;
         eot_valid  <= eot_valid_next;
         if (eot_valid_next) begin
            eot_thread <= msg.thread;
            eot_ffid   <= msg.ff_id; // R17
         end
      end
   end

   //------------------------------------------------------------
   // Header write at dispatch
   //------------------------------------------------------------
   assign hdr_wr_valid_next = disp_valid;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hdr_wr_valid  <= 1'b0;
         hdr_wr_thread <= 3'h0;
         hdr_wr_data   <= 32'h0;
      end else begin
         hdr_wr_valid <= hdr_wr_valid_next;
         if (disp_valid) begin
            hdr_wr_thread <= disp_thread;
            hdr_wr_data   <= 32'(disp_ffid) << `EMW_HDR_FFID_LSB; // R18
         end
      end
   end

   //------------------------------------------------------------
   // APB registers and error capture
   //------------------------------------------------------------
   always_comb begin
      pready_next    = psel & penable & !pready;
      prdata_next    = 32'h0;
      pslverr_next   = 1'b0;
      ctrl_execution_unit_id_next = ctrl_execution_unit_id_reg;
      err_valid_next = err_valid_reg;
      err_info_next  = err_info_reg;
      err_mask_next  = err_mask_reg;
      err_hdr_next   = err_hdr_reg;
      case (paddr)
         `EMW_CTRL_OFS:     prdata_next = {28'h0, ctrl_execution_unit_id_reg};
         `EMW_STATUS_OFS:   prdata_next = {13'h0, cnt_reg, 16'(hung_reg) << 8 | 16'(active_reg)};
         `EMW_ERR_INFO_OFS: prdata_next = err_info_reg | (32'(err_valid_reg) << `EMW_ERR_VALID_BIT);
         `EMW_ERR_MASK_OFS: prdata_next = err_mask_reg;
         `EMW_ERR_HDR_OFS:  prdata_next = err_hdr_reg;
         default:           pslverr_next = pready_next;
      endcase
      if (apb_wr && paddr == `EMW_CTRL_OFS)
         ctrl_execution_unit_id_next = pwdata[3:0];
      if (apb_wr && paddr == `EMW_ERR_INFO_OFS && pwdata[`EMW_ERR_VALID_BIT])
         err_valid_next = 1'b0;
      // New error wins over a clear in the same cycle
      if (pop && deq_bad && !err_valid_reg) begin
         err_valid_next = 1'b1; // R22 R23
         err_info_next  = {10'h0, fifo_mem[rd_ptr_reg].desc.target_function_id,
                           fifo_mem[rd_ptr_reg].desc.payload_len,
                           fifo_mem[rd_ptr_reg].desc.response_len, fifo_mem[rd_ptr_reg].thread,
                           2'h0, fifo_mem[rd_ptr_reg].execution_unit_id};
         err_mask_next  = fifo_mem[rd_ptr_reg].channel_enable_mask;
         err_hdr_next   = {20'h0, fifo_mem[rd_ptr_reg].ff_id, 1'b0, fifo_mem[rd_ptr_reg].dst_start};
      end else if (pop && deq_bad) begin
         err_valid_next = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready        <= 1'b0;
         prdata        <= 32'h0;
         pslverr       <= 1'b0;
         ctrl_execution_unit_id_reg <= `EMW_CTRL_RST;
         err_valid_reg <= 1'b0;
         err_info_reg  <= 32'h0;
         err_mask_reg  <= 32'h0;
         err_hdr_reg   <= 32'h0;
         err_irq       <= 1'b0;
      end else begin
         pready        <= pready_next;
         prdata        <= prdata_next;
         pslverr       <= pslverr_next;
         ctrl_execution_unit_id_reg <= ctrl_execution_unit_id_next;
         err_valid_reg <= err_valid_next;
         err_info_reg  <= err_info_next;
         err_mask_reg  <= err_mask_next;
         err_hdr_reg   <= err_hdr_next;
         err_irq       <= err_valid_next; // R22
      end
   end

   //------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   second_half_a: assert property ((state_reg == ST_SECOND) |=> exe_valid && exe_half) // R1
      else $error("second half not issued");
   sb_mark_a: assert property (push && !ins.dst_null && ins.desc.response_len != 5'h0
                               && !(wb_valid && wb_thread == ins.thread && wb_reg == ins.dst)
                               |=> sb_reg[$past(ins.thread)][$past(ins.dst)]) // R7
      else $error("response register not marked");
   wb_clear_a: assert property (wb_valid && !push |=> !sb_reg[$past(wb_thread)][$past(wb_reg)]) // R9
      else $error("writeback did not clear flag");
   eot_stop_a: assert property (push && ins.desc.thread_end_flag && !disp_valid
                                |=> !active_reg[$past(ins.thread)]) // R14
      else $error("thread still active after end");
   full_stall_a: assert property (fifo_full |-> !push) // R25
      else $error("push into full queue");
   bad_drop_a: assert property (pop && deq_bad |=> err_valid_reg ##1 err_irq) // R23
      else $error("bad message not captured");
   eot_refuse_a: assert property (state_reg == ST_IDLE && ins_valid && ins.is_send
                                  && ins.desc.thread_end_flag && !ins.dst_null |-> !push) // R24
      else $error("illegal thread end issued");
   eot_notify_a: assert property (msg_valid && msg_ready && msg.desc.thread_end_flag
                                  |=> eot_valid && eot_ffid == $past(msg.ff_id)) // R16
      else $error("thread end not notified");
   send_scalar_a: assert property (exe_scalar |-> !exe_half ##1 !exe_valid) // R12
      else $error("send issued as multi-cycle");

   cov_compressed_c: cover property (state_reg == ST_SECOND ##1 exe_half);
   cov_full_c: cover property (fifo_full && ins_valid && ins.is_send);
   cov_error_c: cover property (pop && deq_bad);
   cov_eot_c: cover property (eot_valid);
endmodule

// file: rtl/emw_pkg.sv
// Types for the message send and writeback block
// Assumes emw_consts.svh in the include path
package emw_pkg;
   `include "emw_consts.svh"

   typedef struct packed {
      logic       thread_end_flag;
      logic [3:0] target_function_id;
      logic [3:0] payload_len;
      logic [4:0] response_len;
   } emw_desc_type;

   typedef struct packed {
      logic [2:0]   thread;
      logic         is_send;
      logic         compressed;
      logic [6:0]   src0;
      logic [6:0]   src1;
      logic [6:0]   dst;
      logic         dst_null;
      emw_desc_type desc;
      logic [31:0]  channel_enable_mask;
   } emw_instr_type;

   typedef enum logic [1:0] {
      HDR_SEPARATE = 2'h0,
      HDR_NONE     = 2'h1,
      HDR_MERGED   = 2'h2
   } emw_hdr_type;

   typedef struct packed {
      emw_desc_type desc;
      emw_hdr_type  hdr_kind;
      logic [6:0]   dst_start;
      logic         dst_null;
      logic [6:0]   payload_start;
      logic [31:0]  channel_enable_mask;
      logic [2:0]   thread;
      logic [3:0]   execution_unit_id;
      logic [3:0]   ff_id;
   } emw_msg_type;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_SECOND = 3'b010,
      ST_ACK    = 3'b100
   } emw_state_type;
endpackage

// file: verif/emw_sf_model.sv
// Behavioural shared function units facing the message and writeback ports
// Assumes one clock; stall holds ready low; replies come last register first
`timescale 1ns/100ps

module emw_sf_model
   import emw_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        stall,
   input  wire logic        msg_valid,
   input  wire emw_msg_type msg,
   output logic             msg_ready,
   output logic             wb_valid,
   output logic [2:0]       wb_thread,
   output logic [6:0]       wb_reg
);
   logic [9:0] pend [$];

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         msg_ready <= 1'b0;
         wb_valid <= 1'b0;
         wb_thread <= 3'h0;
         wb_reg <= 7'h0;
         pend.delete();
      end else begin
         msg_ready <= !stall;
         if (msg_valid && msg_ready && !msg.dst_null) begin
            for (int k = 0; k < int'(msg.desc.response_len); k++) begin
               pend.push_front({msg.thread, msg.dst_start + 7'(k)});
            end
         end
         if (pend.size() > 0) begin
            wb_valid <= 1'b1;
            {wb_thread, wb_reg} <= pend.pop_front();
         end else begin
            // Idle lines toggle so stale values never look valid
            wb_valid <= 1'b0;
            wb_thread <= ~wb_thread;
            wb_reg <= ~wb_reg;
         end
      end
   end
endmodule

// file: verif/eu_message_send_writeback_test.sv
// Self-checking bench for the message send and writeback block
// Assumes emw_pkg, emw_consts.svh and the shared function model
`timescale 1ns/100ps
`include "emw_consts.svh"

module eu_message_send_writeback_test import emw_pkg::*;;
   logic          pclk, presetn, psel, penable, pwrite, ins_valid, disp_valid, stall;
   logic          pready, pslverr, ins_done, exe_valid, exe_half, exe_scalar, msg_valid;
   logic          msg_ready, wb_valid, hdr_wr_valid, eot_valid, err_irq, got, err, scal;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata, hdr_wr_data, rd, hd;
   logic [2:0]    exe_thread, wb_thread, disp_thread, hdr_wr_thread, eot_thread;
   logic [6:0]    wb_reg;
   logic [3:0]    disp_ffid, eot_ffid, halves;
   logic [6:0]    eo;
   emw_instr_type ins;
   emw_msg_type   msg;
   emw_msg_type   seen [$];
   int            num_errors = 0, tests_run = 0, n_exe = 0, n_eot = 0;
   logic [3:0]    codes [7] = '{`EMW_SF_MATH, `EMW_SF_SAMPLER, `EMW_SF_GATEWAY,
      `EMW_SF_DATAPORT, `EMW_SF_PIXEL, `EMW_SF_URB, `EMW_SF_SPAWNER};

   emw_msg_send i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .ins_valid, .ins, .ins_done, .exe_valid, .exe_half, .exe_scalar,
      .exe_thread, .msg_valid, .msg, .msg_ready, .wb_valid, .wb_thread, .wb_reg,
      .disp_valid, .disp_thread, .disp_ffid, .hdr_wr_valid, .hdr_wr_thread, .hdr_wr_data,
      .eot_valid, .eot_thread, .eot_ffid, .err_irq);
   emw_sf_model i_sf (.pclk, .presetn, .stall, .msg_valid, .msg, .msg_ready, .wb_valid,
      .wb_thread, .wb_reg);

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // Port monitors
   always @(posedge pclk) begin
      if (exe_valid === 1'b1) begin
         n_exe++;
         halves = {halves[2:0], exe_half};
         scal = exe_scalar;
      end
      if (msg_valid === 1'b1 && msg_ready === 1'b1) seen.push_back(msg);
      if (eot_valid === 1'b1) begin
         n_eot++;
         eo = {eot_thread, eot_ffid};
      end
      if (hdr_wr_valid === 1'b1) hd = hdr_wr_data;
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] act);
      tests_run++;
      if (act !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, act);
      end
   endtask

   task automatic stop_test;
      $display("Comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic dispatch(input logic [2:0] t, input logic [3:0] f);
      @(posedge pclk);
      disp_valid <= 1'b1;
      disp_thread <= t;
      disp_ffid <= f;
      @(posedge pclk);
      disp_valid <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask

   function automatic emw_instr_type mk(input logic [2:0] t, input logic s, input logic c,
         input logic [6:0] s0, input logic [6:0] d, input logic n, input logic [13:0] dsc);
      mk = '0;
      mk.thread = t;
      mk.is_send = s;
      mk.compressed = c;
      mk.src0 = s0;
      mk.src1 = s0;
      mk.dst = d;
      mk.dst_null = n;
      mk.desc = dsc;
      mk.channel_enable_mask = 32'ha5c3_0f96;
   endfunction

   function automatic emw_hdr_type hk(input logic [3:0] c);
      hk = (c == `EMW_SF_MATH) ? HDR_NONE : (c == `EMW_SF_GATEWAY) ? HDR_MERGED : HDR_SEPARATE;
   endfunction

   task automatic wt(input int lim);
      for (int k = 0; k < lim && !got; k++) begin
         @(posedge pclk);
         got = (ins_done === 1'b1);
      end
      if (got) ins_valid <= 1'b0;
   endtask

   task automatic issue(input emw_instr_type i, input int lim);
      @(posedge pclk);
      ins <= i;
      ins_valid <= 1'b1;
      got = 1'b0;
      wt(lim);
   endtask

   task automatic t_regs;
      apb(1'b0, `EMW_CTRL_OFS, 32'h0);
      chk("ctrl_reset", 32'h0, rd);
      apb(1'b1, `EMW_CTRL_OFS, 32'h5);
      apb(1'b0, 12'h0f0, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, err});
   endtask

   task automatic t_disp;
      dispatch(3'h0, 4'ha);
      chk("hdr_ffid", 4'ha, hd[`EMW_HDR_FFID_LSB +: 4]);
      dispatch(3'h1, 4'h3);
      chk("hdr_thread", {3'h1, 4'h3}, {hdr_wr_thread, hd[`EMW_HDR_FFID_LSB +: 4]});
      dispatch(3'h2, 4'h6);
   endtask

   task automatic t_compr;
      int n0 = n_exe;
      issue(mk(3'h0, 1'b0, 1'b1, 7'h20, 7'h30, 1'b1, 14'h0), 20);
      chk("compr_halves", {8'h2, 2'b01}, {8'(n_exe - n0), halves[1:0]});
   endtask

   task automatic t_dep;
      int n0 = seen.size();
      stall <= 1'b1;
      issue(mk(3'h0, 1'b1, 1'b0, 7'h10, 7'h40, 1'b0, {1'b0, `EMW_SF_SAMPLER, 4'h2, 5'h2}), 20);
      chk("send_scalar", 2'b11, {got, scal});
      issue(mk(3'h0, 1'b0, 1'b0, 7'h41, 7'h22, 1'b1, 14'h0), 15);
      chk("dep_blocked", 1'b0, got);
      stall <= 1'b0;
      wt(40);
      chk("dep_released", 1'b1, got);
      chk("msg_fields", {`EMW_SF_SAMPLER, 4'h2, 5'h2, 7'h40, 4'h5, 3'h0}, {
         seen[n0].desc.target_function_id, seen[n0].desc.payload_len,
         seen[n0].desc.response_len, seen[n0].dst_start, seen[n0].execution_unit_id,
         seen[n0].thread});
      chk("msg_mask", 32'ha5c3_0f96, seen[n0].channel_enable_mask);
   endtask

   task automatic t_order;
      int base = seen.size();
      int nd = 0;
      stall <= 1'b1;
      foreach (codes[k]) begin
         issue(mk(3'h0, 1'b1, 1'b0, 7'h10, 7'h0, 1'b1, {1'b0, codes[k], 4'h1, 5'h0}), 20);
         if (!got) break;
         nd++;
      end
      chk("queue_stall", 1'b1, nd < 7);
      stall <= 1'b0;
      wt(40);
      for (int k = nd + 1; k < 7; k++) begin
         issue(mk(3'h0, 1'b1, 1'b0, 7'h10, 7'h0, 1'b1, {1'b0, codes[k], 4'h1, 5'h0}), 20);
      end
      repeat (20) @(posedge pclk);
      foreach (codes[k]) begin
         chk("order_route", {codes[k], hk(codes[k])},
            {seen[base+k].desc.target_function_id, seen[base+k].hdr_kind});
      end
   endtask

   task automatic t_eot;
      int n0 = n_eot;
      int e0;
      issue(mk(3'h0, 1'b1, 1'b0, 7'h0, 7'h0, 1'b1, {1'b1, `EMW_SF_PIXEL, 4'h1, 5'h0}), 20);
      repeat (10) @(posedge pclk);
      chk("eot_seen", {8'h1, 3'h0, 4'ha}, {8'(n_eot - n0), eo});
      e0 = n_exe;
      issue(mk(3'h0, 1'b0, 1'b0, 7'h20, 7'h21, 1'b1, 14'h0), 20);
      chk("ended_discard", {1'b1, 8'h0}, {got, 8'(n_exe - e0)});
      n0 = seen.size();
      e0 = n_exe;
      issue(mk(3'h1, 1'b1, 1'b0, 7'h0, 7'h50, 1'b0, {1'b1, `EMW_SF_URB, 4'h1, 5'h1}), 20);
      issue(mk(3'h1, 1'b0, 1'b0, 7'h20, 7'h21, 1'b1, 14'h0), 20);
      repeat (10) @(posedge pclk);
      chk("eot_dest_refused", {8'h0, 8'h0}, {8'(seen.size() - n0), 8'(n_exe - e0)});
   endtask

   task automatic t_err;
      int n0 = seen.size();
      issue(mk(3'h2, 1'b1, 1'b0, 7'h10, 7'h60, 1'b0, {1'b0, 4'hf, 4'h1, 5'h1}), 20);
      repeat (10) @(posedge pclk);
      chk("bad_id_dropped", {8'h0, 1'b1, 3'h2},
         {8'(seen.size() - n0), err_irq, exe_thread});
      apb(1'b0, `EMW_ERR_INFO_OFS, 32'h0);
      chk("err_info", {1'b1, 4'hf}, {rd[`EMW_ERR_VALID_BIT], rd[21:18]});
      apb(1'b0, `EMW_ERR_HDR_OFS, 32'h0);
      chk("err_hdr", 32'h0000_0660, rd);
      apb(1'b1, `EMW_ERR_INFO_OFS, 32'h8000_0000);
      repeat (3) @(posedge pclk);
      chk("err_cleared", 1'b0, err_irq);
      issue(mk(3'h2, 1'b0, 1'b0, 7'h60, 7'h22, 1'b1, 14'h0), 20);
      chk("dest_in_flight", 1'b0, got);
   endtask

   initial begin
      {psel, penable, pwrite, ins_valid, disp_valid, stall} = '0;
      paddr = '0;
      pwdata = '0;
      ins = '0;
      disp_thread = '0;
      disp_ffid = '0;
      presetn = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_disp;
      t_compr;
      t_dep;
      t_order;
      t_eot;
      t_err;
      stop_test;
   end

   initial begin
      #20000;
      num_errors++;
      stop_test;
   end
endmodule
